// ---- pkg/gcsh_pkg.sv ----
package gcsh_pkg;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam int WB_AW = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CONFIG = 8'h08;
  localparam logic [7:0] ADR_GSTAT = 8'h0c;
  localparam int TOG_BIT = 7;
  localparam int CODE_HI = 6;
  localparam int CODE_LO = 4;
  localparam int EXT_HI = 3;
  localparam int EXT_LO = 0;
  localparam int NODE_LO = 8;
  localparam int NODE_HI = 15;
  localparam int STATE_LO = 16;
  localparam int STATE_HI = 17;
  localparam int CFG_MASTER_BIT = 0;
  localparam int CFG_PERMIT_BIT = 1;
  localparam logic [15:0] CTRL_RST = 16'h0070;
  localparam logic [7:0] STAT_RST = 8'h70;
  // ----------------------------------------
  // Commands, extensions, nodes
  // ----------------------------------------
  localparam logic [2:0] CMD_SET_NMT = 3'h0;
  localparam logic [2:0] CMD_GET_NODE = 3'h1;
  localparam logic [2:0] CMD_GET_GEN = 3'h2;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [3:0] EXT_PREOP = 4'h0;
  localparam logic [3:0] EXT_OPER = 4'h1;
  localparam logic [3:0] EXT_RST_NODE = 4'h2;
  localparam logic [3:0] EXT_RST_COMM = 4'h3;
  localparam logic [3:0] EXT_STOP = 4'h4;
  localparam logic [3:0] EXT_UNKNOWN = 4'h5;
  localparam logic [3:0] EXT_MISSING = 4'h6;
  localparam logic [3:0] EXT_ERROR = 4'hf;
  localparam logic [7:0] NODE_SELF = 8'h00;
  localparam logic [7:0] NODE_ALL = 8'h80;
  localparam int GS_BUS_OFF = 0;
  localparam int GS_ERR_PASV = 1;
  localparam int GS_SUPV = 2;
  localparam int GS_SYNC = 3;
  localparam logic [15:0] EMCY_CODE = 16'hff10;
  localparam int NODES = 127;
  localparam int NODE_W = 7;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    NMT_INIT = 2'b00,
    NMT_PREOP = 2'b01,
    NMT_OPER = 2'b10,
    NMT_STOP = 2'b11
  } gcsh_nmt_t;
endpackage

// ---- rtl/gcsh_node_table.sv ----
`timescale 1ns/10ps
module gcsh_node_table #(
  parameter int NODES = gcsh_pkg::NODES,
  parameter int NW = gcsh_pkg::NODE_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic upd_valid,
  input wire logic [NW-1:0] upd_node,
  input wire logic upd_supervised,
  input wire logic [3:0] upd_state,
  input wire logic [NW-1:0] rd_node,
  output logic [3:0] rd_state,
  output logic any_error,
  output logic [NW-1:0] low_error
);
  logic [3:0] state_mem [1:NODES];
  logic [NODES:1] supv;
  logic [NODES:1] err;

  // Node state and supervision flags, written by the supervision engine
  always_ff @(posedge clk) begin
    if (!rstn) begin
      supv <= '0;
      for (int i = 1; i <= NODES; i++) begin
        state_mem[i] <= gcsh_pkg::EXT_UNKNOWN;
      end
    end else if (ce && upd_valid && upd_node != '0) begin
      supv[upd_node] <= upd_supervised;
      state_mem[upd_node] <= upd_state;
    end
  end

  // Per-node fault, only for supervised nodes
  for (genvar g = 1; g <= NODES; g++) begin : g_err
    assign err[g] = supv[g] && (state_mem[g] == gcsh_pkg::EXT_MISSING ||
                    state_mem[g] == gcsh_pkg::EXT_ERROR);
  end

  // Lowest faulty node wins
  always_comb begin
    low_error = '0;
    for (int i = NODES; i >= 1; i--) begin
      if (err[i]) begin
        low_error = NW'(i);
      end
    end
  end

  assign any_error = |err;
  assign rd_state = (rd_node != '0 && supv[rd_node]) ? state_mem[rd_node] :
                    gcsh_pkg::EXT_UNKNOWN;

  a_unsup_no_err: assert property (@(posedge clk) disable iff (!rstn)
    (supv == '0) |-> !any_error) else $error("fault shown for unsupervised node");
endmodule // gcsh_node_table

// ---- rtl/gcsh_emcy_tx.sv ----
`timescale 1ns/10ps
module gcsh_emcy_tx #(
  parameter logic [15:0] CODE = gcsh_pkg::EMCY_CODE
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic req,
  output logic emcy_valid,
  output logic [15:0] emcy_code,
  input wire logic emcy_ready
);
  // Pending emergency held until the network side takes it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      emcy_valid <= 1'b0;
    end else if (ce) begin
      if (req) begin
        emcy_valid <= 1'b1;
      end else if (emcy_ready) begin
        emcy_valid <= 1'b0;
      end
    end
  end

  assign emcy_code = CODE;

  a_emcy_hold: assert property (@(posedge clk) disable iff (!rstn)
    emcy_valid && !emcy_ready |=> emcy_valid) else $error("emergency dropped early");
endmodule // gcsh_emcy_tx

// ---- rtl/gcsh_ctrl.sv ----
`timescale 1ns/10ps
module gcsh_ctrl #(
  parameter int INIT_CYCLES = gcsh_pkg::INIT_CYCLES,
  parameter int NODES = gcsh_pkg::NODES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gcsh_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sec_start_req,
  input wire logic upd_valid,
  input wire logic [gcsh_pkg::NODE_W-1:0] upd_node,
  input wire logic upd_supervised,
  input wire logic [3:0] upd_state,
  input wire logic bus_off,
  input wire logic error_passive_flag,
  input wire logic sync_fail,
  output logic [15:0] status_word,
  output logic io_exchange_en,
  output logic [1:0] nmt_state,
  output logic nmt_req_valid,
  output logic [3:0] nmt_req_cs,
  output logic [7:0] nmt_req_node,
  output logic reload_config,
  output logic reload_comm,
  output logic emcy_valid,
  output logic [15:0] emcy_code,
  input wire logic emcy_ready
);
  localparam int CW = $clog2(INIT_CYCLES + 1);

  gcsh_pkg::gcsh_nmt_t state;
  gcsh_pkg::gcsh_nmt_t next_state;
  logic [15:0] ctrl;
  logic [1:0] cfg;
  logic [7:0] stat0;
  logic [7:0] err_node;
  logic op_permit;
  logic [CW-1:0] init_cnt;
  logic wr_ack;
  logic cw_new;
  logic exec;
  logic [2:0] cmd;
  logic [3:0] ext;
  logic [7:0] node;
  logic master_role;
  logic to_self;
  logic set_nmt;
  logic emcy_req;
  logic [3:0] local_code;
  logic [3:0] tbl_state;
  logic any_error;
  logic [gcsh_pkg::NODE_W-1:0] low_error;
  logic [3:0] gen_status;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Read data captured when the request is first seen
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      gcsh_pkg::ADR_CTRL: rd_mux[15:0] = ctrl;
      gcsh_pkg::ADR_STATUS: begin
        rd_mux[15:0] = status_word;
        rd_mux[gcsh_pkg::STATE_HI:gcsh_pkg::STATE_LO] = state;
      end
      gcsh_pkg::ADR_CONFIG: rd_mux[1:0] = cfg;
      gcsh_pkg::ADR_GSTAT: rd_mux[3:0] = gen_status;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_dat_o <= '0;
    end else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Control word register, written by the primary master
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl <= gcsh_pkg::CTRL_RST;
    end else if (ce && wr_ack && wb_adr_i == gcsh_pkg::ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Role configuration; permit bit is read-only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      master_role <= 1'b0;
    end else if (ce && wr_ack && wb_adr_i == gcsh_pkg::ADR_CONFIG && wb_sel_i[0]) begin
      master_role <= wb_dat_i[gcsh_pkg::CFG_MASTER_BIT];
    end
  end

  // Readback view of role and permit, one driver for the whole word
  always_comb begin
    cfg = '0;
    cfg[gcsh_pkg::CFG_MASTER_BIT] = master_role;
    cfg[gcsh_pkg::CFG_PERMIT_BIT] = op_permit;
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------

  // Field split of byte 0 and node byte
  assign cmd = ctrl[gcsh_pkg::CODE_HI:gcsh_pkg::CODE_LO];
  assign ext = ctrl[gcsh_pkg::EXT_HI:gcsh_pkg::EXT_LO];
  assign node = ctrl[gcsh_pkg::NODE_HI:gcsh_pkg::NODE_LO];
  assign cw_new = ctrl[gcsh_pkg::TOG_BIT] != stat0[gcsh_pkg::TOG_BIT];
  assign exec = cw_new && state != gcsh_pkg::NMT_INIT;
  assign to_self = !master_role || node == gcsh_pkg::NODE_SELF ||
                   node == gcsh_pkg::NODE_ALL;
  assign set_nmt = exec && cmd == gcsh_pkg::CMD_SET_NMT &&
                   ext <= gcsh_pkg::EXT_STOP;
  assign gen_status = {sync_fail, any_error, error_passive_flag, bus_off};

  // Own state as a node-state code
  always_comb begin
    unique case (state)
      gcsh_pkg::NMT_INIT: local_code = gcsh_pkg::EXT_RST_COMM;
      gcsh_pkg::NMT_PREOP: local_code = gcsh_pkg::EXT_PREOP;
      gcsh_pkg::NMT_OPER: local_code = gcsh_pkg::EXT_OPER;
      gcsh_pkg::NMT_STOP: local_code = gcsh_pkg::EXT_STOP;
    endcase
  end

  gcsh_node_table #(
    .NODES(NODES),
    .NW(gcsh_pkg::NODE_W)
  ) u_table (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .upd_valid(upd_valid),
    .upd_node(upd_node),
    .upd_supervised(upd_supervised),
    .upd_state(upd_state),
    .rd_node(node[gcsh_pkg::NODE_W-1:0]),
    .rd_state(tbl_state),
    .any_error(any_error),
    .low_error(low_error)
  );

  // ----------------------------------------
  // Status word
  // ----------------------------------------

  // Accept a new command: mirror toggle, echo code and answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stat0 <= gcsh_pkg::STAT_RST;
    end else if (ce && exec) begin
      unique case (cmd)
        gcsh_pkg::CMD_SET_NMT: begin
          if (ext <= gcsh_pkg::EXT_STOP) begin
            stat0 <= {ctrl[gcsh_pkg::TOG_BIT], cmd, ext};
          end
        end
        gcsh_pkg::CMD_GET_NODE: begin
          if (node == gcsh_pkg::NODE_SELF) begin
            stat0 <= {ctrl[gcsh_pkg::TOG_BIT], cmd, local_code};
          end else if (node == gcsh_pkg::NODE_ALL) begin
            stat0 <= {ctrl[gcsh_pkg::TOG_BIT], cmd,
                      any_error ? gcsh_pkg::EXT_ERROR : local_code};
          end else begin
            stat0 <= {ctrl[gcsh_pkg::TOG_BIT], cmd, tbl_state};
          end
        end
        gcsh_pkg::CMD_GET_GEN: stat0 <= {ctrl[gcsh_pkg::TOG_BIT], cmd, gen_status};
        gcsh_pkg::CMD_NOP: stat0 <= {ctrl[gcsh_pkg::TOG_BIT], cmd, ext};
        default: stat0 <= stat0;
      endcase
    end
  end

  // Lowest faulty supervised node
  always_ff @(posedge clk) begin
    if (!rstn) begin
      err_node <= '0;
    end else if (ce) begin
      err_node <= {1'b0, low_error};
    end
  end

  assign status_word = {err_node, stat0};

  // ----------------------------------------
  // Local NMT state machine
  // ----------------------------------------

  // Initialization time, then pre-operational on its own
  always_ff @(posedge clk) begin
    if (!rstn) begin
      init_cnt <= '0;
    end else if (ce) begin
      if (state == gcsh_pkg::NMT_INIT) begin
        init_cnt <= init_cnt + CW'(1);
      end else begin
        init_cnt <= '0;
      end
    end
  end

  always_comb begin
    next_state = state;
    emcy_req = 1'b0;
    unique case (state)
      gcsh_pkg::NMT_INIT: begin
        if (init_cnt == CW'(INIT_CYCLES - 1)) begin
          next_state = gcsh_pkg::NMT_PREOP;
        end
      end
      default: begin
        if (sec_start_req) begin
          if (op_permit) begin
            next_state = gcsh_pkg::NMT_OPER;
          end else begin
            emcy_req = 1'b1;
          end
        end
        if (set_nmt && to_self) begin
          unique case (ext)
            gcsh_pkg::EXT_PREOP: begin
              next_state = gcsh_pkg::NMT_PREOP;
              emcy_req = 1'b1;
            end
            gcsh_pkg::EXT_OPER: begin
              if (master_role) begin
                next_state = gcsh_pkg::NMT_OPER;
              end
            end
            gcsh_pkg::EXT_STOP: next_state = gcsh_pkg::NMT_STOP;
            default: next_state = gcsh_pkg::NMT_INIT;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= gcsh_pkg::NMT_INIT;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Permission for operational, granted only by the primary master
  always_ff @(posedge clk) begin
    if (!rstn) begin
      op_permit <= 1'b0;
    end else if (ce && set_nmt && to_self) begin
      op_permit <= ext == gcsh_pkg::EXT_OPER || ext == gcsh_pkg::EXT_STOP;
    end
  end

  // Reload strobes and NMT requests to remote nodes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reload_config <= 1'b0;
      reload_comm <= 1'b0;
      nmt_req_valid <= 1'b0;
      nmt_req_cs <= '0;
      nmt_req_node <= '0;
    end else if (ce) begin
      reload_config <= set_nmt && to_self && ext == gcsh_pkg::EXT_RST_NODE;
      reload_comm <= set_nmt && to_self && ext == gcsh_pkg::EXT_RST_COMM;
      nmt_req_valid <= set_nmt && master_role && node != gcsh_pkg::NODE_SELF;
      if (set_nmt && master_role) begin
        nmt_req_cs <= ext;
        nmt_req_node <= node;
      end
    end
  end

  assign io_exchange_en = state == gcsh_pkg::NMT_OPER;
  assign nmt_state = state;

  gcsh_emcy_tx #(
    .CODE(gcsh_pkg::EMCY_CODE)
  ) u_emcy (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .req(emcy_req && ce),
    .emcy_valid(emcy_valid),
    .emcy_code(emcy_code),
    .emcy_ready(emcy_ready)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_toggle_mirror: assert property (@(posedge clk) disable iff (!rstn)
    ce && exec && cmd == gcsh_pkg::CMD_NOP |=>
    status_word[gcsh_pkg::TOG_BIT] == $past(ctrl[gcsh_pkg::TOG_BIT]))
    else $error("status toggle not mirrored");
  a_repeat_ignored: assert property (@(posedge clk) disable iff (!rstn)
    !cw_new |=> $stable(stat0)) else $error("repeated control word executed");
  a_echo_code: assert property (@(posedge clk) disable iff (!rstn)
    ce && set_nmt |=> stat0[gcsh_pkg::CODE_HI:gcsh_pkg::EXT_LO] == $past(ctrl[6:0]))
    else $error("set state not echoed");
  a_err_node: assert property (@(posedge clk) disable iff (!rstn)
    ce && !any_error |=> err_node == 8'h00) else $error("error node not zero");
  a_reject_emcy: assert property (@(posedge clk) disable iff (!rstn)
    ce && sec_start_req && !op_permit && state != gcsh_pkg::NMT_INIT |=> emcy_valid)
    else $error("start not refused");
  a_preop_emcy: assert property (@(posedge clk) disable iff (!rstn)
    ce && set_nmt && to_self && ext == gcsh_pkg::EXT_PREOP |=>
    emcy_valid && state == gcsh_pkg::NMT_PREOP) else $error("no emergency on preop");
  a_init_auto: assert property (@(posedge clk) disable iff (!rstn)
    ce && state == gcsh_pkg::NMT_INIT && init_cnt == CW'(INIT_CYCLES - 1) |=>
    state == gcsh_pkg::NMT_PREOP) else $error("no automatic preop");
  a_oper_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(io_exchange_en) |-> $past(set_nmt || (sec_start_req && op_permit)))
    else $error("operational without command");
  a_reset_init: assert property (@(posedge clk) disable iff (!rstn)
    reload_config || reload_comm |-> state == gcsh_pkg::NMT_INIT)
    else $error("reset without reinit");
  c_oper: cover property (@(posedge clk) disable iff (!rstn) $rose(io_exchange_en));
  c_emcy: cover property (@(posedge clk) disable iff (!rstn) emcy_valid && emcy_ready);
  c_node_query: cover property (@(posedge clk) disable iff (!rstn)
    exec && cmd == gcsh_pkg::CMD_GET_NODE);
endmodule // gcsh_ctrl

// ---- sim/gcsh_plc_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Primary master and emergency sink
// ----------------------------------------
module gcsh_plc_model (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic [31:0] rdat,
  input wire logic ack,
  input wire logic emcy_valid,
  output logic emcy_ready,
  output int emcy_seen
);
  logic tog = 1'b0;
  int stall = 0;
  // Idle bus and no emergency taken yet
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
    emcy_ready = 1'b0;
    emcy_seen = 0;
  end
  // One classic cycle, held until ack is sampled at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output bit ok);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h3, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    ok = (ack === 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  // A new command always flips the toggle first
  task automatic command(input logic [2:0] c, input logic [3:0] x, input logic [7:0] nd,
      output bit ok);
    logic [31:0] q;
    tog = ~tog;
    xfer(1'b1, gcsh_pkg::ADR_CTRL, {16'h0, nd, tog, c, x}, q, ok);
  endtask
  // Takes an emergency only after a short stall
  always @(posedge clk) begin
    if (emcy_valid === 1'b1 && stall == 2) begin
      emcy_ready <= 1'b1;
      stall <= 3;
    end else if (emcy_ready) begin
      emcy_ready <= 1'b0;
      emcy_seen <= emcy_seen + 1;
      stall <= 0;
    end else if (emcy_valid === 1'b1) begin
      stall <= stall + 1;
    end
  end
endmodule // gcsh_plc_model

// ---- sim/gateway_control_status_handshake_tb.sv ----
`timescale 1ns/10ps
module gateway_control_status_handshake_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sec_start_req = 1'b0;
  logic upd_valid = 1'b0;
  logic [6:0] upd_node = 7'h00;
  logic upd_supervised = 1'b0;
  logic [3:0] upd_state = 4'h0;
  logic bus_off = 1'b0;
  logic error_passive_flag = 1'b0;
  logic sync_fail = 1'b0;
  logic ce = 1'b1;
  logic [3:0] req_cs = 4'h0;
  logic cyc, stb, we, ack, io_exchange_en, nmt_req_valid, reload_config, reload_comm;
  logic emcy_valid, emcy_ready;
  logic [7:0] adr, nmt_req_node, last;
  logic [7:0] req_node = 8'h00;
  logic [3:0] sel, nmt_req_cs;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] status_word, emcy_code;
  logic [1:0] nmt_state;
  int err_count = 0;
  int tests_run = 0;
  int n_reload = 0;
  int n_comm = 0;
  int n_req = 0;
  int n_emcy;
  bit ok;
  // Clock at 8 ns
  always #4 clk = ~clk;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  gcsh_ctrl #(.INIT_CYCLES(4)) dut (
    .clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sec_start_req(sec_start_req), .upd_valid(upd_valid), .upd_node(upd_node),
    .upd_supervised(upd_supervised), .upd_state(upd_state), .bus_off(bus_off),
    .error_passive_flag(error_passive_flag), .sync_fail(sync_fail),
    .status_word(status_word), .io_exchange_en(io_exchange_en), .nmt_state(nmt_state),
    .nmt_req_valid(nmt_req_valid), .nmt_req_cs(nmt_req_cs), .nmt_req_node(nmt_req_node),
    .reload_config(reload_config), .reload_comm(reload_comm), .emcy_valid(emcy_valid),
    .emcy_code(emcy_code), .emcy_ready(emcy_ready));
  gcsh_plc_model u_plc (
    .clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat),
    .rdat(rdat), .ack(ack), .emcy_valid(emcy_valid), .emcy_ready(emcy_ready),
    .emcy_seen());
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard;
    if (!ok) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_plc.xfer(w, a, d, rd, ok);
    guard();
    repeat (3) @(posedge clk);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [3:0] x, input logic [7:0] nd);
    u_plc.command(c, x, nd, ok);
    guard();
    repeat (3) @(posedge clk);
  endtask
  task automatic st(input logic [7:0] en, input logic [2:0] c, input logic [3:0] x);
    check({16'h0, status_word}, {16'h0, en, u_plc.tog, c, x});
  endtask
  task automatic upd(input logic [6:0] nd, input logic sv, input logic [3:0] s);
    @(posedge clk);
    {upd_valid, upd_node, upd_supervised, upd_state} <= {1'b1, nd, sv, s};
    @(posedge clk);
    upd_valid <= 1'b0;
  endtask
  task automatic start_req;
    @(posedge clk);
    sec_start_req <= 1'b1;
    @(posedge clk);
    sec_start_req <= 1'b0;
  endtask
  task automatic wait_state(input logic [1:0] s);
    for (int n = 0; nmt_state !== s && n < 40; n++) @(posedge clk);
    check({30'h0, nmt_state}, {30'h0, s});
  endtask
  task automatic wait_emcy(input int n);
    for (int k = 0; u_plc.emcy_seen < n && k < 40; k++) @(posedge clk);
    check(32'(u_plc.emcy_seen), 32'(n));
  endtask
  // Records one-cycle pulses and checks the emergency code
  always @(posedge clk) begin
    if (reload_config === 1'b1) n_reload++;
    if (reload_comm === 1'b1) n_comm++;
    if (nmt_req_valid === 1'b1) req_node = nmt_req_node;
    if (nmt_req_valid === 1'b1) n_req++;
    if (nmt_req_valid === 1'b1) req_cs = nmt_req_cs;
    if (emcy_valid === 1'b1) check({16'h0, emcy_code}, {16'h0, gcsh_pkg::EMCY_CODE});
  end
  // Cuts a hang short
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({16'h0, status_word}, 32'h0070);
    wait_state(gcsh_pkg::NMT_PREOP);
    rw(1'b1, gcsh_pkg::ADR_CONFIG, 32'h1);
    rw(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    cmd(3'h0, 4'h1, 8'h00);
    st(8'h00, 3'h0, 4'h1);
    check({31'h0, io_exchange_en}, 32'h1);
    last = status_word[7:0];
    rw(1'b1, gcsh_pkg::ADR_CTRL, {16'h0, 8'h00, u_plc.tog, 3'h0, 4'h4});
    check({24'h0, status_word[7:0]}, {24'h0, last});
    rw(1'b0, gcsh_pkg::ADR_STATUS, 32'h0);
    check(rd, 32'h0002_0081);
    upd(7'd5, 1'b1, 4'hf);
    upd(7'd3, 1'b0, 4'hf);
    upd(7'd9, 1'b1, 4'h6);
    repeat (2) @(posedge clk);
    check({24'h0, status_word[15:8]}, 32'h5);
    cmd(3'h1, 4'h0, 8'h05);
    st(8'h05, 3'h1, 4'hf);
    cmd(3'h1, 4'h0, 8'h09);
    st(8'h05, 3'h1, 4'h6);
    cmd(3'h1, 4'h0, 8'h03);
    st(8'h05, 3'h1, 4'h5);
    cmd(3'h1, 4'h0, 8'h00);
    st(8'h05, 3'h1, 4'h1);
    bus_off <= 1'b1;
    sync_fail <= 1'b1;
    cmd(3'h2, 4'h0, 8'h00);
    st(8'h05, 3'h2, 4'hd);
    {bus_off, sync_fail, error_passive_flag} <= 3'b001;
    upd(7'd5, 1'b1, 4'h1);
    upd(7'd9, 1'b1, 4'h1);
    cmd(3'h2, 4'h0, 8'h00);
    st(8'h00, 3'h2, 4'h2);
    // A fault written while the clock enable is low must not land
    ce <= 1'b0;
    upd(7'd5, 1'b1, 4'hf);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    check({24'h0, status_word[15:8]}, 32'h0);
    cmd(3'h0, 4'h1, 8'h02);
    check({24'h0, req_node}, 32'h2);
    cmd(3'h0, 4'h4, 8'h80);
    check({24'h0, req_node}, 32'h80);
    check({28'h0, req_cs}, 32'h4);
    check(32'(n_req), 32'h2);
    wait_state(gcsh_pkg::NMT_STOP);
    last = status_word[7:0];
    for (int i = 0; i < 5; i++) begin
      rw(1'b1, gcsh_pkg::ADR_CTRL, {16'h0, 8'h00, ~u_plc.tog,
        (i < 4) ? 3'(i + 3) : 3'h0, (i < 4) ? 4'h0 : 4'h5});
      check({24'h0, status_word[7:0]}, {24'h0, last});
    end
    n_emcy = u_plc.emcy_seen;
    cmd(3'h0, 4'h0, 8'h00);
    wait_state(gcsh_pkg::NMT_PREOP);
    wait_emcy(n_emcy + 1);
    rw(1'b1, gcsh_pkg::ADR_CONFIG, 32'h0);
    start_req();
    wait_emcy(n_emcy + 2);
    check({30'h0, nmt_state}, {30'h0, gcsh_pkg::NMT_PREOP});
    cmd(3'h0, 4'h1, 8'h00);
    rw(1'b0, gcsh_pkg::ADR_CONFIG, 32'h0);
    check({31'h0, rd[1]}, 32'h1);
    start_req();
    wait_state(gcsh_pkg::NMT_OPER);
    for (int i = 0; i < 2; i++) begin
      cmd(3'h0, 4'(2 + i), 8'h00);
      wait_state(gcsh_pkg::NMT_PREOP);
    end
    check({n_reload[15:0], n_comm[15:0]}, 32'h0001_0001);
    cmd(3'h7, 4'h0, 8'h00);
    st(8'h00, 3'h7, 4'h0);
    complete_run();
  end
endmodule // gateway_control_status_handshake_tb
